// ### hdl/hcp_dev_end.sv
// device end of the host cpu port: e-clock and strobe modes, clock divider, rts guard
`timescale 1ns/1ps
`default_nettype none
module hcp_dev_end (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    hcp_if.dev                              bus,
    input  wire logic                       asyncMode,
    input  wire logic                       earlyReady,
    input  wire logic                       divSel,
    output logic                            memValid,
    output logic                            memWrite,
    output logic [hcp_pkg::ADDR_W-1:0]      memAddr,
    output logic [hcp_pkg::DATA_W-1:0]      memWdata,
    input  wire logic [hcp_pkg::DATA_W-1:0] memRdata,
    input  wire logic                       txValid,
    input  wire logic                       txBit,
    output logic                            txReady,
    output logic                            rts,
    output logic                            txd
);
    typedef enum logic [1:0] {
        DV_IDLE   = 2'b01,
        DV_ACTIVE = 2'b10
    } hcp_dev_state_t;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_LEAD = 4'b0010,
        TX_SEND = 4'b0100,
        TX_TAIL = 4'b1000
    } hcp_tx_state_t;

    // pin synchronisers; stage 0 is read only by stage 1
    logic [2:0]                  csSync;
    logic [2:0]                  rwSync;
    logic [2:0]                  eSync;
    logic [2:0]                  asSync;
    logic [hcp_pkg::ADDR_W-1:0]  addrS1;
    logic [hcp_pkg::ADDR_W-1:0]  addrS2;
    logic [hcp_pkg::DATA_W-1:0]  dataS1;
    logic [hcp_pkg::DATA_W-1:0]  dataS2;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            csSync <= 3'h7;
            rwSync <= 3'h7;
            eSync  <= 3'h0;
            asSync <= 3'h7;
            addrS1 <= '0;
            addrS2 <= '0;
            dataS1 <= '0;
            dataS2 <= '0;
        end else begin
            csSync <= {csSync[1:0], bus.chipSelectN};
            rwSync <= {rwSync[1:0], bus.readNotWrite};
            eSync  <= {eSync[1:0], bus.eClk};
            asSync <= {asSync[1:0], bus.addrStrobeN};
            addrS1 <= bus.addr;
            addrS2 <= addrS1;
            dataS1 <= bus.busData;
            dataS2 <= dataS1;
        end
    end

    logic selected;
    logic dirRead;
    logic eRise;
    logic eFall;
    logic asFall;
    logic asRise;

    assign selected = ~csSync[1];
    assign dirRead  = rwSync[1];
    assign eRise    = eSync[1] & ~eSync[2];
    assign eFall    = ~eSync[1] & eSync[2];
    assign asFall   = ~asSync[1] & asSync[2];
    assign asRise   = asSync[1] & ~asSync[2];

    // access engine
    hcp_dev_state_t             state;
    hcp_dev_state_t             next_state;
    logic [hcp_pkg::CNT_W-1:0]  cnt;
    logic [hcp_pkg::CNT_W-1:0]  next_cnt;
    logic                       isRead;
    logic                       next_isRead;
    logic                       isReg;
    logic                       next_isReg;
    logic [hcp_pkg::ADDR_W-1:0] accAddr;
    logic [hcp_pkg::ADDR_W-1:0] next_accAddr;
    logic                       ackN;
    logic                       next_ackN;
    logic                       dOe;
    logic                       next_dOe;
    logic [hcp_pkg::DATA_W-1:0] dOut;
    logic [hcp_pkg::DATA_W-1:0] next_dOut;
    logic                       next_memValid;
    logic                       next_memWrite;
    logic [hcp_pkg::ADDR_W-1:0] next_memAddr;
    logic [hcp_pkg::DATA_W-1:0] next_memWdata;
    logic [hcp_pkg::CNT_W-1:0]  ackAt;
    logic [hcp_pkg::CNT_W-1:0]  dataAt;
    logic                       accessEnd;

    // counts start one cycle after the synchronised edge
    assign ackAt = earlyReady
        ? hcp_pkg::CNT_W'(hcp_pkg::ACK_EARLY_CYC - hcp_pkg::SYNC_LAG)
        : hcp_pkg::CNT_W'(hcp_pkg::ACK_NORM_CYC - hcp_pkg::SYNC_LAG);
    // registers are slower than ram, so their data is latched later
    // one cycle to enter the active state and one to register the data
    assign dataAt = isReg
        ? hcp_pkg::CNT_W'(hcp_pkg::DATA_REG_CYC - hcp_pkg::SYNC_LAG - 2)
        : hcp_pkg::CNT_W'(hcp_pkg::DATA_RAM_CYC - hcp_pkg::SYNC_LAG - 2);
    assign accessEnd = asyncMode ? asRise : eFall;

    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_isRead   = isRead;
        next_isReg    = isReg;
        next_accAddr  = accAddr;
        next_ackN     = ackN;
        next_dOe      = dOe;
        next_dOut     = dOut;
        next_memValid = 1'b0;
        next_memWrite = memWrite;
        next_memAddr  = memAddr;
        next_memWdata = memWdata;
        unique case (state)
            DV_IDLE: begin
                if ((asyncMode && asFall && selected)
                    || (!asyncMode && eRise && selected && dirRead)) begin
                    next_state   = DV_ACTIVE;
                    next_cnt     = '0;
                    next_isRead  = dirRead;
                    next_isReg   = addrS2 < hcp_pkg::REG_LIMIT;
                    next_accAddr = addrS2;
                    next_dOe     = dirRead;
                    if (dirRead) begin
                        next_memValid = 1'b1;
                        next_memWrite = 1'b0;
                        next_memAddr  = addrS2;
                    end
                end else if (!asyncMode && eFall && selected && !dirRead) begin
                    // data is sampled through the same two stages as the strobe
                    next_memValid = 1'b1;
                    next_memWrite = 1'b1;
                    next_memAddr  = addrS2;
                    next_memWdata = dataS2;
                end
            end
            DV_ACTIVE: begin
                if (cnt != '1) begin
                    next_cnt = cnt + 1'b1;
                end
                if (isRead && cnt == dataAt) begin
                    next_dOut = memRdata;
                end
                if (asyncMode && cnt == ackAt) begin
                    next_ackN = 1'b0;
                end
                if (accessEnd) begin
                    next_state = DV_IDLE;
                    next_ackN  = 1'b1;
                    next_dOe   = 1'b0;
                    if (asyncMode && !isRead) begin
                        // strobe-mode write commits on the strobe rise
                        next_memValid = 1'b1;
                        next_memWrite = 1'b1;
                        next_memAddr  = accAddr;
                        next_memWdata = dataS2;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state    <= DV_IDLE;
            cnt      <= '0;
            isRead   <= 1'b0;
            isReg    <= 1'b0;
            accAddr  <= '0;
            ackN     <= 1'b1;
            dOe      <= 1'b0;
            dOut     <= '0;
            memValid <= 1'b0;
            memWrite <= 1'b0;
            memAddr  <= '0;
            memWdata <= '0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            isRead   <= next_isRead;
            isReg    <= next_isReg;
            accAddr  <= next_accAddr;
            ackN     <= next_ackN;
            dOe      <= next_dOe;
            dOut     <= next_dOut;
            memValid <= next_memValid;
            memWrite <= next_memWrite;
            memAddr  <= next_memAddr;
            memWdata <= next_memWdata;
        end
    end

    assign bus.dataAckN  = ackN;
    assign bus.devDataOe = dOe;
    assign bus.devData   = dOut;

    // divided clock out, divide by four when select is low
    logic [1:0] divCnt;
    logic [1:0] next_divCnt;
    logic       divClk;
    logic       next_divClk;

    always_comb begin
        next_divCnt = divCnt + 2'h1;
        next_divClk = divSel ? next_divCnt[0] : next_divCnt[1];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            divCnt <= 2'h0;
            divClk <= 1'b0;
        end else begin
            divCnt <= next_divCnt;
            divClk <= next_divClk;
        end
    end

    assign bus.dividedClockOut = divClk;

    // request-to-send guard around the serial transmit data
    hcp_tx_state_t             txState;
    hcp_tx_state_t             next_txState;
    logic [hcp_pkg::CNT_W-1:0] txCnt;
    logic [hcp_pkg::CNT_W-1:0] next_txCnt;
    logic                      next_rts;
    logic                      next_txd;

    always_comb begin
        next_txState = txState;
        next_txCnt   = txCnt;
        next_rts     = rts;
        next_txd     = 1'b1;
        unique case (txState)
            TX_IDLE: begin
                if (txValid) begin
                    next_rts     = 1'b1;
                    next_txCnt   = '0;
                    next_txState = TX_LEAD;
                end
            end
            TX_LEAD: begin
                next_txCnt = txCnt + 1'b1;
                if (txCnt == hcp_pkg::CNT_W'(hcp_pkg::RTS_GUARD_CYC - 1)) begin
                    next_txState = TX_SEND;
                end
            end
            TX_SEND: begin
                if (txValid) begin
                    next_txd = txBit;
                end else begin
                    next_txCnt   = '0;
                    next_txState = TX_TAIL;
                end
            end
            TX_TAIL: begin
                next_txCnt = txCnt + 1'b1;
                // new data inside the tail resumes without a fresh lead
                if (txValid) begin
                    next_txState = TX_SEND;
                end else if (txCnt == hcp_pkg::CNT_W'(hcp_pkg::RTS_GUARD_CYC - 1)) begin
                    next_rts     = 1'b0;
                    next_txState = TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txState <= TX_IDLE;
            txCnt   <= '0;
            rts     <= 1'b0;
            txd     <= 1'b1;
        end else begin
            txState <= next_txState;
            txCnt   <= next_txCnt;
            rts     <= next_rts;
            txd     <= next_txd;
        end
    end

    assign txReady = (txState == TX_SEND);
endmodule
`default_nettype wire

// ### hdl/hcp_pkg.sv
// shared constants for the host cpu port, both ends
package hcp_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 6;
    // internal core clock period and the documented period T (48 MHz)
    localparam int CLK_PS = 5000;
    localparam int T_PS   = 20833;
    // addresses below this hit registers/latches, the rest hits ram
    localparam logic [ADDR_W-1:0] REG_LIMIT = 11'h016;
    // edge detection lag of the pin synchronisers, in cycles
    localparam int SYNC_LAG = 2;
    // device timing, in ps
    localparam int ACK_NORM_MIN_PS  = 4 * T_PS + 5000;
    localparam int ACK_EARLY_MIN_PS = 3 * T_PS + 5000;
    localparam int DATA_RAM_MAX_PS  = 4 * T_PS + 5000;
    localparam int DATA_REG_MAX_PS  = 4 * T_PS + 18000;
    localparam int RTS_GUARD_PS     = 4 * T_PS;
    // host timing, in ps
    localparam int SETUP_PS      = 10000;
    localparam int HOLD_PS       = 10000;
    localparam int E_HIGH_PS     = 3 * T_PS + 74200;
    localparam int AS_RD_MIN_PS  = 6 * T_PS - 10000;
    localparam int AS_WR_MIN_PS  = 4 * T_PS;
    localparam int ACCESS_GAP_PS = 6 * T_PS;
    // least times round up, longest times round down
    localparam int ACK_NORM_CYC  = (ACK_NORM_MIN_PS + CLK_PS - 1) / CLK_PS;
    localparam int ACK_EARLY_CYC = (ACK_EARLY_MIN_PS + CLK_PS - 1) / CLK_PS;
    localparam int DATA_RAM_CYC  = DATA_RAM_MAX_PS / CLK_PS;
    localparam int DATA_REG_CYC  = DATA_REG_MAX_PS / CLK_PS;
    localparam int RTS_GUARD_CYC = (RTS_GUARD_PS + CLK_PS - 1) / CLK_PS;
    localparam int SETUP_CYC     = (SETUP_PS + CLK_PS - 1) / CLK_PS;
    localparam int HOLD_CYC      = (HOLD_PS + CLK_PS - 1) / CLK_PS;
    localparam int E_HIGH_CYC    = (E_HIGH_PS + CLK_PS - 1) / CLK_PS;
    localparam int AS_RD_CYC     = (AS_RD_MIN_PS + CLK_PS - 1) / CLK_PS;
    localparam int AS_WR_CYC     = (AS_WR_MIN_PS + CLK_PS - 1) / CLK_PS;
    localparam int GAP_CYC       = (ACCESS_GAP_PS + CLK_PS - 1) / CLK_PS;
    // idle level of the floating data bus
    localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
endpackage

// ### hdl/hcp_if.sv
// pin bundle between the host cpu and the device port
`timescale 1ns/1ps
`default_nettype none
interface hcp_if;
    logic                       chipSelectN;
    logic                       readNotWrite;
    logic                       eClk;
    logic                       addrStrobeN;
    logic                       dataAckN;
    logic                       dividedClockOut;
    logic [hcp_pkg::ADDR_W-1:0] addr;
    logic [hcp_pkg::DATA_W-1:0] hostData;
    logic                       hostDataOe;
    logic [hcp_pkg::DATA_W-1:0] devData;
    logic                       devDataOe;
    logic [hcp_pkg::DATA_W-1:0] busData;

    // resolved bus level, pulled up when nobody drives
    assign busData = devDataOe ? devData : (hostDataOe ? hostData : hcp_pkg::BUS_IDLE);

    modport dev (
        input  chipSelectN, readNotWrite, eClk, addrStrobeN, addr, busData,
        output dataAckN, dividedClockOut, devData, devDataOe
    );
    modport host (
        input  dataAckN, dividedClockOut, busData,
        output chipSelectN, readNotWrite, eClk, addrStrobeN, addr, hostData, hostDataOe
    );
endinterface
`default_nettype wire

// ### hdl/hcp_host_end.sv
// host cpu end of the port: runs e-clock or strobe cycles with the required spacing
`timescale 1ns/1ps
`default_nettype none
module hcp_host_end (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    hcp_if.host                             bus,
    input  wire logic                       cmdValid,
    output logic                            cmdReady,
    input  wire logic                       cmdWrite,
    input  wire logic                       cmdAsync,
    input  wire logic [hcp_pkg::ADDR_W-1:0] cmdAddr,
    input  wire logic [hcp_pkg::DATA_W-1:0] cmdWdata,
    output logic                            rspValid,
    output logic [hcp_pkg::DATA_W-1:0]      rspData
);
    typedef enum logic [4:0] {
        HS_IDLE   = 5'b00001,
        HS_SETUP  = 5'b00010,
        HS_STROBE = 5'b00100,
        HS_HOLD   = 5'b01000,
        HS_GAP    = 5'b10000
    } hcp_host_state_t;

    logic [1:0]                 ackSync;
    logic [hcp_pkg::DATA_W-1:0] dataS1;
    logic [hcp_pkg::DATA_W-1:0] dataS2;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ackSync <= 2'h3;
            dataS1  <= '0;
            dataS2  <= '0;
        end else begin
            ackSync <= {ackSync[0], bus.dataAckN};
            dataS1  <= bus.busData;
            dataS2  <= dataS1;
        end
    end

    hcp_host_state_t            state;
    hcp_host_state_t            next_state;
    logic [hcp_pkg::CNT_W-1:0]  cnt;
    logic [hcp_pkg::CNT_W-1:0]  next_cnt;
    logic                       csN;
    logic                       next_csN;
    logic                       rw;
    logic                       next_rw;
    logic [hcp_pkg::ADDR_W-1:0] adr;
    logic [hcp_pkg::ADDR_W-1:0] next_adr;
    logic [hcp_pkg::DATA_W-1:0] wdat;
    logic [hcp_pkg::DATA_W-1:0] next_wdat;
    logic                       dOe;
    logic                       next_dOe;
    logic                       eClk;
    logic                       next_eClk;
    logic                       asN;
    logic                       next_asN;
    logic                       isAsync;
    logic                       next_isAsync;
    logic                       next_rspValid;
    logic [hcp_pkg::DATA_W-1:0] next_rspData;
    logic [hcp_pkg::CNT_W-1:0]  strobeMin;

    assign strobeMin = rw ? hcp_pkg::CNT_W'(hcp_pkg::AS_RD_CYC - 1)
                          : hcp_pkg::CNT_W'(hcp_pkg::AS_WR_CYC - 1);

    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_csN      = csN;
        next_rw       = rw;
        next_adr      = adr;
        next_wdat     = wdat;
        next_dOe      = dOe;
        next_eClk     = eClk;
        next_asN      = asN;
        next_isAsync  = isAsync;
        next_rspValid = 1'b0;
        next_rspData  = rspData;
        unique case (state)
            HS_IDLE: begin
                if (cmdValid) begin
                    next_state   = HS_SETUP;
                    next_cnt     = '0;
                    next_csN     = 1'b0;
                    next_rw      = ~cmdWrite;
                    next_adr     = cmdAddr;
                    next_wdat    = cmdWdata;
                    next_dOe     = cmdWrite;
                    next_isAsync = cmdAsync;
                end
            end
            HS_SETUP: begin
                next_cnt = cnt + 1'b1;
                if (cnt == hcp_pkg::CNT_W'(hcp_pkg::SETUP_CYC - 1)) begin
                    next_state = HS_STROBE;
                    next_cnt   = '0;
                    if (isAsync) begin
                        next_asN = 1'b0;
                    end else begin
                        next_eClk = 1'b1;
                    end
                end
            end
            HS_STROBE: begin
                if (cnt != '1) begin
                    next_cnt = cnt + 1'b1;
                end
                // strobe mode waits for the acknowledge and the least pulse width
                if (isAsync ? (!ackSync[1] && cnt >= strobeMin)
                            : (cnt == hcp_pkg::CNT_W'(hcp_pkg::E_HIGH_CYC - 1))) begin
                    next_state = HS_HOLD;
                    next_cnt   = '0;
                    next_asN   = 1'b1;
                    next_eClk  = 1'b0;
                    if (rw) begin
                        next_rspValid = 1'b1;
                        next_rspData  = dataS2;
                    end
                end
            end
            HS_HOLD: begin
                next_cnt = cnt + 1'b1;
                if (cnt == hcp_pkg::CNT_W'(hcp_pkg::HOLD_CYC - 1)) begin
                    next_state = HS_GAP;
                    next_cnt   = '0;
                    next_csN   = 1'b1;
                    next_dOe   = 1'b0;
                end
            end
            HS_GAP: begin
                // one gap covers the read-to-select, select-to-write and write spacing
                next_cnt = cnt + 1'b1;
                if (cnt == hcp_pkg::CNT_W'(hcp_pkg::GAP_CYC - 1)) begin
                    next_state = HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state    <= HS_IDLE;
            cnt      <= '0;
            csN      <= 1'b1;
            rw       <= 1'b1;
            adr      <= '0;
            wdat     <= '0;
            dOe      <= 1'b0;
            eClk     <= 1'b0;
            asN      <= 1'b1;
            isAsync  <= 1'b0;
            rspValid <= 1'b0;
            rspData  <= '0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            csN      <= next_csN;
            rw       <= next_rw;
            adr      <= next_adr;
            wdat     <= next_wdat;
            dOe      <= next_dOe;
            eClk     <= next_eClk;
            asN      <= next_asN;
            isAsync  <= next_isAsync;
            rspValid <= next_rspValid;
            rspData  <= next_rspData;
        end
    end

    assign cmdReady         = (state == HS_IDLE);
    assign bus.chipSelectN  = csN;
    assign bus.readNotWrite = rw;
    assign bus.addr         = adr;
    assign bus.hostData     = wdat;
    assign bus.hostDataOe   = dOe;
    assign bus.eClk         = eClk;
    assign bus.addrStrobeN  = asN;
endmodule
`default_nettype wire

// ### testbench/hcp_monitor.sv
// pin assertions for the host cpu port
`timescale 1ns/1ps
`default_nettype none
module hcp_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic chipSelectN,
    input wire logic readNotWrite,
    input wire logic eClk,
    input wire logic addrStrobeN,
    input wire logic dataAckN,
    input wire logic devDataOe,
    input wire logic hostDataOe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    AST_ACK_MIN: assert property ($fell(addrStrobeN) && !chipSelectN |->
        dataAckN [*8] ##1 dataAckN [*6]) else $error("ack early");
    AST_ACK_MAX: assert property ($fell(addrStrobeN) && !chipSelectN |->
        ##[1:23] !dataAckN) else $error("ack late");
    AST_ACK_FREE: assert property ($rose(addrStrobeN) && !dataAckN |->
        ##[1:5] dataAckN) else $error("ack held");
    AST_ACK_CAUSE: assert property (!dataAckN |->
        !$past(addrStrobeN, 4)) else $error("ack without strobe");
    AST_RD_DATA: assert property ($fell(addrStrobeN) && !chipSelectN && readNotWrite |->
        ##20 devDataOe) else $error("read data late");
    AST_NO_FIGHT: assert property (!(devDataOe && hostDataOe)) else $error("bus fight");
    AST_SYNC_RD: assert property ($rose(eClk) && !chipSelectN && readNotWrite |->
        ##[1:4] devDataOe) else $error("no read drive");
    AST_WR_QUIET: assert property (!chipSelectN && !readNotWrite |->
        !devDataOe) else $error("drive in write");
endmodule
`default_nettype wire

// ### testbench/host_cpu_port_motorola_modes_test.sv
// bench joining host end and device end
`timescale 1ns/1ps
`default_nettype none
module host_cpu_port_motorola_modes_test;
    logic clk = '0, nrst = '0, cmdValid = '0, cmdWrite = '0, cmdAsync = '0, txBit = '1;
    logic asyncMode = '0, earlyReady = '0, divSel = '0, txValid = '0;
    logic cmdReady, rspValid, memValid, memWrite, txReady, rts, txd;
    logic [10:0] cmdAddr = '0, memAddr, wAddr;
    logic [7:0] cmdWdata = '0, rspData, memWdata, memRdata, wData, q;
    int bad_count = 0, check_count = 0, n;
    hcp_if bus ();
    // memory stand-in: data derived from address so every read is predictable
    assign memRdata = memAddr[7:0] ^ 8'h5A;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (memValid && memWrite) begin
        wAddr <= memAddr;
        wData <= memWdata;
    end
    hcp_dev_end i_hcp_dev_end (.clk(clk), .nrst(nrst), .bus(bus), .asyncMode(asyncMode),
        .earlyReady(earlyReady), .divSel(divSel), .memValid(memValid), .memWrite(memWrite),
        .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .txValid(txValid),
        .txBit(txBit), .txReady(txReady), .rts(rts), .txd(txd));
    hcp_host_end i_hcp_host_end (.clk(clk), .nrst(nrst), .bus(bus), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAsync(cmdAsync), .cmdAddr(cmdAddr),
        .cmdWdata(cmdWdata), .rspValid(rspValid), .rspData(rspData));
    hcp_monitor i_hcp_monitor (.clk(clk), .nrst(nrst), .chipSelectN(bus.chipSelectN),
        .readNotWrite(bus.readNotWrite), .eClk(bus.eClk), .addrStrobeN(bus.addrStrobeN),
        .dataAckN(bus.dataAckN), .devDataOe(bus.devDataOe), .hostDataOe(bus.hostDataOe));
    task test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task check(input logic [23:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // every polling wait goes through here, so a hang ends the run
    task step;
        @(posedge clk);
        #1;
        n++;
        if (n > 300) begin
            bad_count++;
            $display("wait limit hit at %0t", $time);
            test_done;
        end
    endtask
    task op(input logic wr, as, input logic [10:0] a, input logic [7:0] d);
        for (n = 0; cmdReady !== 1'b1;) step;
        {cmdWrite, cmdAsync, asyncMode, cmdAddr, cmdWdata, cmdValid} = {wr, as, as, a, d, 1'b1};
        step;
        cmdValid = '0;
        for (n = 0; !wr && rspValid !== 1'b1;) step;
        q = rspData;
        for (n = 0; wr && cmdReady !== 1'b1;) step;
        if (!wr) check(24'(q), 24'(a[7:0] ^ 8'h5A));
        else check({wData, 5'h00, wAddr}, {d, 5'h00, a});
    endtask
    task rise;
        logic p;
        n = 0;
        do begin
            p = bus.dividedClockOut;
            step;
        end while (!(p === 1'b0 && bus.dividedClockOut === 1'b1));
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = '1;
        repeat (3) @(posedge clk);
        #1;
        op(1'b0, 1'b0, 11'h005, 8'h00);
        op(1'b0, 1'b0, 11'h123, 8'h00);
        op(1'b1, 1'b0, 11'h015, 8'hC3);
        $display("e-clock test done");
        for (int e = 0; e < 2; e++) begin
            earlyReady = e[0];
            op(1'b0, 1'b1, 11'h015, 8'h00);
            op(1'b0, 1'b1, 11'h016, 8'h00);
            op(1'b1, 1'b1, 11'h7FF, 8'h3C);
        end
        $display("strobe test done");
        for (int s = 0; s < 2; s++) begin
            divSel = s[0];
            rise;
            rise;
            check(24'(n), s ? 24'h000002 : 24'h000004);
        end
        $display("divider test done");
        txValid = '1;
        for (n = 0; rts !== 1'b1;) step;
        for (n = 0; txReady !== 1'b1;) step;
        check(24'(n >= hcp_pkg::RTS_GUARD_CYC), 24'h000001);
        txBit = '0;
        step;
        check(24'(txd), 24'h000000);
        txBit = '1;
        txValid = '0;
        for (n = 0; rts !== 1'b0;) step;
        check(24'(n >= hcp_pkg::RTS_GUARD_CYC), 24'h000001);
        $display("serial test done");
        test_done;
    end
endmodule
`default_nettype wire
